// file: src/pcsst_pkg.sv
// Constants for the coding-sublayer status and capability register group
package pcsst_pkg;

  // Management device address answered by this group
  localparam logic [4:0]  PCSST_DEVAD           = 5'h03;

  // Register offsets in the device's management space
  localparam logic [15:0] PCSST_OFS_STATUS_TWO  = 16'h0008;
  localparam logic [15:0] PCSST_OFS_PKG_ID_LOW  = 16'h000e;
  localparam logic [15:0] PCSST_OFS_PKG_ID_HIGH = 16'h000f;
  localparam logic [15:0] PCSST_OFS_LPI_CAP     = 16'h0014;
  localparam logic [15:0] PCSST_OFS_WAKE_ERR    = 16'h0016;

  // Field positions in pcs_status_two
  localparam int PCSST_BIT_DEV_HI    = 15;
  localparam int PCSST_BIT_DEV_LO    = 14;
  localparam int PCSST_BIT_FIVE_T    = 13;
  localparam int PCSST_BIT_TWOP5_T   = 12;
  localparam int PCSST_BIT_TX_FAULT  = 11;
  localparam int PCSST_BIT_RX_FAULT  = 10;
  localparam int PCSST_BIT_RSV_HI    = 9;
  localparam int PCSST_BIT_RSV_LO    = 4;
  localparam int PCSST_BIT_TEN_T     = 3;
  localparam int PCSST_BIT_TEN_W     = 2;
  localparam int PCSST_BIT_TEN_X     = 1;
  localparam int PCSST_BIT_TEN_R     = 0;

  // Field positions in low_power_idle_capability
  localparam int PCSST_BIT_LPI_KR    = 6;
  localparam int PCSST_BIT_LPI_KX4   = 5;
  localparam int PCSST_BIT_LPI_KX    = 4;
  localparam int PCSST_BIT_LPI_TEN_T = 3;
  localparam int PCSST_BIT_LPI_GIG_T = 2;
  localparam int PCSST_BIT_LPI_FAST  = 1;

  // Fixed field values
  localparam logic [1:0]  PCSST_DEV_PRESENT     = 2'h2;
  localparam logic        PCSST_ABLE            = 1'b1;
  localparam logic        PCSST_NOT_ABLE        = 1'b0;

  // Reset values
  localparam logic [15:0] PCSST_RST_RDATA       = 16'h0000;
  localparam logic [15:0] PCSST_RST_WAKE_ERR    = 16'h0000;
  localparam logic        PCSST_RST_RX_LATCH    = 1'b0;

  // Counter width
  localparam int PCSST_WAKE_ERR_W = 16;

endpackage

// file: src/pcsst_regs.sv
// Coding-sublayer status and capability registers on the management port
`timescale 1ns/100ps

// What this block does
// - The device-present field of pcs_status_two reads binary 10.
// - Bit 13 of pcs_status_two reads 1 for five-gig twisted-pair ability.
// - Bit 12 of pcs_status_two reads 1 for 2.5G twisted-pair ability.
// - Bit 3 of pcs_status_two reads 1 for ten-gig twisted-pair ability.
// - Bits 2, 1 and 0 of pcs_status_two read 0 for unsupported codings.
// - Bit 11 shows the live transmit-path fault and has no reset of its own.
// - Bit 10 latches high on any receive-path fault and resets to 0.
// - A 32-bit package identifier is read as low then high 16-bit words.
// - Bit 3 of the capability register reports ten-gig twisted-pair idle.
// - Capability bits 6, 5, 4, 2 and 1 read 0.
// - The wake-error counter steps on every wake-time fault.
// - The wake-error counter clears on a read and on a sublayer reset.
// - The wake-error counter saturates at all ones.
module pcsst_regs #(
  parameter logic [15:0] PKG_ID_LOW      = 16'ha5c3, // Arbitrary value
  parameter logic [15:0] PKG_ID_HIGH     = 16'h5a3c, // Arbitrary value
  parameter logic        LPI_TEN_T_ABLE  = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        pcs_reset_in,
  input  wire logic [4:0]  mgmt_devad_in,
  input  wire logic [15:0] mgmt_addr_in,
  input  wire logic        mgmt_rd_in,
  input  wire logic        transmit_path_fault_in,
  input  wire logic        receive_path_fault_in,
  input  wire logic        wake_time_fault_in,
  output logic      [15:0] mgmt_rdata_out,
  output logic             mgmt_rvalid_out
);

  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rvalid_q;
  logic        rx_latch_q;
  logic        rd_status_two;
  logic        rd_wake_err;
  logic        our_read;
  logic [15:0] wake_error_counter;
  logic [15:0] status_two;
  logic [15:0] lpi_cap;

  function automatic logic reads_reg(input logic       rd,
                                     input logic [4:0]  devad,
                                     input logic [15:0] addr,
                                     input logic [15:0] target);
    reads_reg = rd && devad == pcsst_pkg::PCSST_DEVAD && addr == target;
  endfunction

  assign our_read      = mgmt_rd_in &&
                         mgmt_devad_in == pcsst_pkg::PCSST_DEVAD;
  assign rd_status_two = reads_reg(mgmt_rd_in, mgmt_devad_in, mgmt_addr_in,
                                   pcsst_pkg::PCSST_OFS_STATUS_TWO);
  assign rd_wake_err   = reads_reg(mgmt_rd_in, mgmt_devad_in, mgmt_addr_in,
                                   pcsst_pkg::PCSST_OFS_WAKE_ERR);

  // Receive fault latch; a fault in the reading cycle keeps it set
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pcs_reset_in)
      rx_latch_q <= pcsst_pkg::PCSST_RST_RX_LATCH;
    else
      rx_latch_q <= receive_path_fault_in ||
                    (rx_latch_q && !rd_status_two);
  end

  pcsst_sat_counter #(
    .WIDTH      (pcsst_pkg::PCSST_WAKE_ERR_W)
  ) u_wake_err (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pcs_rst_in (pcs_reset_in),
    .rd_clr_in  (rd_wake_err),
    .inc_in     (wake_time_fault_in),
    .count_out  (wake_error_counter)
  );

  always_comb
  begin
    status_two = 16'h0000;
    status_two[pcsst_pkg::PCSST_BIT_DEV_HI:pcsst_pkg::PCSST_BIT_DEV_LO] =
      pcsst_pkg::PCSST_DEV_PRESENT;
    status_two[pcsst_pkg::PCSST_BIT_FIVE_T]   = pcsst_pkg::PCSST_ABLE;
    status_two[pcsst_pkg::PCSST_BIT_TWOP5_T]  = pcsst_pkg::PCSST_ABLE;
    status_two[pcsst_pkg::PCSST_BIT_TX_FAULT] =
      transmit_path_fault_in;
    status_two[pcsst_pkg::PCSST_BIT_RX_FAULT] = rx_latch_q;
    status_two[pcsst_pkg::PCSST_BIT_TEN_T]    = pcsst_pkg::PCSST_ABLE;
    status_two[pcsst_pkg::PCSST_BIT_TEN_W]    = pcsst_pkg::PCSST_NOT_ABLE;
    status_two[pcsst_pkg::PCSST_BIT_TEN_X]    = pcsst_pkg::PCSST_NOT_ABLE;
    status_two[pcsst_pkg::PCSST_BIT_TEN_R]    = pcsst_pkg::PCSST_NOT_ABLE;
  end

  always_comb
  begin
    lpi_cap = 16'h0000;
    lpi_cap[pcsst_pkg::PCSST_BIT_LPI_KR]    = pcsst_pkg::PCSST_NOT_ABLE;
    lpi_cap[pcsst_pkg::PCSST_BIT_LPI_KX4]   = pcsst_pkg::PCSST_NOT_ABLE;
    lpi_cap[pcsst_pkg::PCSST_BIT_LPI_KX]    = pcsst_pkg::PCSST_NOT_ABLE;
    lpi_cap[pcsst_pkg::PCSST_BIT_LPI_TEN_T] = LPI_TEN_T_ABLE;
    lpi_cap[pcsst_pkg::PCSST_BIT_LPI_GIG_T] = pcsst_pkg::PCSST_NOT_ABLE;
    lpi_cap[pcsst_pkg::PCSST_BIT_LPI_FAST]  = pcsst_pkg::PCSST_NOT_ABLE;
  end

  // Read mux; unmapped offsets of this device read as zero
  always_comb
  begin
    case (mgmt_addr_in)
      pcsst_pkg::PCSST_OFS_STATUS_TWO:  rdata_d = status_two;
      pcsst_pkg::PCSST_OFS_PKG_ID_LOW:  rdata_d = PKG_ID_LOW;
      pcsst_pkg::PCSST_OFS_PKG_ID_HIGH: rdata_d = PKG_ID_HIGH;
      pcsst_pkg::PCSST_OFS_LPI_CAP:     rdata_d = lpi_cap;
      pcsst_pkg::PCSST_OFS_WAKE_ERR:    rdata_d = wake_error_counter;
      default:                          rdata_d = 16'h0000;
    endcase
  end

  // Data holds between reads so a slow serial shifter can sample it late
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      rdata_q <= pcsst_pkg::PCSST_RST_RDATA;
    else if (our_read)
      rdata_q <= rdata_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= our_read;
  end

  assign mgmt_rdata_out  = rdata_q;
  assign mgmt_rvalid_out = rvalid_q;

  // Checks

  a_dev_present: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two |=> mgmt_rvalid_out && mgmt_rdata_out[15:14] == 2'h2)
    else $error("device present field wrong");

  a_five_ability: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two |=> mgmt_rdata_out[13])
    else $error("five gig ability not reported");

  a_twop5_ability: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two |=> mgmt_rdata_out[12])
    else $error("2.5G ability not reported");

  a_ten_ability: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two |=> mgmt_rdata_out[3] && mgmt_rdata_out[2:0] == 3'h0)
    else $error("ten gig coding bits wrong");

  a_tx_fault_live: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two |=> mgmt_rdata_out[11] == $past(transmit_path_fault_in))
    else $error("transmit fault bit does not follow input");

  a_rx_fault_latch: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    receive_path_fault_in && !pcs_reset_in ##1 rd_status_two
    |=> mgmt_rdata_out[10])
    else $error("receive fault not latched");

  a_rx_read_clear: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two && !receive_path_fault_in |=> !rx_latch_q)
    else $error("receive fault latch not cleared by read");

  a_pkg_id_words: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    reads_reg(mgmt_rd_in, mgmt_devad_in, mgmt_addr_in,
              pcsst_pkg::PCSST_OFS_PKG_ID_HIGH)
    |=> mgmt_rdata_out == PKG_ID_HIGH)
    else $error("package identifier high word wrong");

  a_pkg_id_low: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    reads_reg(mgmt_rd_in, mgmt_devad_in, mgmt_addr_in,
              pcsst_pkg::PCSST_OFS_PKG_ID_LOW)
    |=> mgmt_rdata_out == PKG_ID_LOW)
    else $error("package identifier low word wrong");

  a_lpi_caps: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    reads_reg(mgmt_rd_in, mgmt_devad_in, mgmt_addr_in,
              pcsst_pkg::PCSST_OFS_LPI_CAP)
    |=> mgmt_rdata_out[3] == LPI_TEN_T_ABLE &&
        mgmt_rdata_out[6:4] == 3'h0 && mgmt_rdata_out[2:1] == 2'h0)
    else $error("idle capability bits wrong");

  a_reserved_zero: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two |=> mgmt_rdata_out[9:4] == 6'h00)
    else $error("reserved status bits not zero");

  a_wake_read: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    // A fault in the reading cycle legally leaves a count of one
    rd_wake_err && !wake_time_fault_in
    ##1 !wake_time_fault_in && !pcs_reset_in && !rd_wake_err
    |=> wake_error_counter == 16'h0000)
    else $error("wake counter survived its read");

  c_rx_fault_read: cover property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_status_two && rx_latch_q);

  c_wake_read: cover property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_wake_err && wake_error_counter != 16'h0000);

  c_pkg_low: cover property (@(posedge clk_in)
    disable iff (sys_rst_in)
    reads_reg(mgmt_rd_in, mgmt_devad_in, mgmt_addr_in,
              pcsst_pkg::PCSST_OFS_PKG_ID_LOW));

  c_clear_with_fault: cover property (@(posedge clk_in)
    disable iff (sys_rst_in)
    rd_wake_err && wake_time_fault_in);

endmodule

// file: src/pcsst_sat_counter.sv
// Saturating wake-error counter, cleared on read or coding-sublayer reset
`timescale 1ns/100ps
module pcsst_sat_counter #(
  parameter int WIDTH = pcsst_pkg::PCSST_WAKE_ERR_W
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             pcs_rst_in,
  input  wire logic             rd_clr_in,
  input  wire logic             inc_in,
  output logic      [WIDTH-1:0] count_out
);

  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ONE      = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count_q;

  assign count_out = count_q;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pcs_rst_in)
      count_q <= WIDTH'(pcsst_pkg::PCSST_RST_WAKE_ERR);
    else if (rd_clr_in)
      // A fault arriving with the clearing read still counts
      count_q <= inc_in ? ONE : WIDTH'(0);
    else if (inc_in && count_q != ALL_ONES)
      count_q <= count_q + ONE;
  end

  a_wake_counts: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    inc_in && !rd_clr_in && !pcs_rst_in && count_q != ALL_ONES
    |=> count_q == $past(count_q) + ONE)
    else $error("wake error count did not step");

  a_read_clears: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (rd_clr_in && !inc_in) || pcs_rst_in |=> count_q == WIDTH'(0))
    else $error("wake error count not cleared");

  a_count_holds: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    count_q == ALL_ONES && !rd_clr_in && !pcs_rst_in
    |=> count_q == ALL_ONES)
    else $error("wake error count wrapped");

  c_saturated: cover property (@(posedge clk_in)
    disable iff (sys_rst_in)
    count_q == ALL_ONES && inc_in);

endmodule

// file: verification/pcsst_regs_tb_top.sv
// Self-checking testbench for the coding-sublayer status register group
`timescale 1ns/100ps
module pcsst_regs_tb_top;
  logic        clk_in                 = 1'b0;
  logic        sys_rst_in             = 1'b1;
  logic        pcs_reset_in           = 1'b0;
  logic [4:0]  mgmt_devad_in          = 5'h00;
  logic [15:0] mgmt_addr_in           = 16'h0000;
  logic        mgmt_rd_in             = 1'b0;
  logic        transmit_path_fault_in = 1'b0;
  logic        receive_path_fault_in  = 1'b0;
  logic        wake_time_fault_in     = 1'b0;
  logic [15:0] mgmt_rdata_out;
  logic        mgmt_rvalid_out;
  int          fails                  = 0;
  int          tests_run              = 0;

  pcsst_regs DUT (
    .clk_in                 (clk_in),
    .sys_rst_in             (sys_rst_in),
    .pcs_reset_in           (pcs_reset_in),
    .mgmt_devad_in          (mgmt_devad_in),
    .mgmt_addr_in           (mgmt_addr_in),
    .mgmt_rd_in             (mgmt_rd_in),
    .transmit_path_fault_in (transmit_path_fault_in),
    .receive_path_fault_in  (receive_path_fault_in),
    .wake_time_fault_in     (wake_time_fault_in),
    .mgmt_rdata_out         (mgmt_rdata_out),
    .mgmt_rvalid_out        (mgmt_rvalid_out)
  );

  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string       name,
                       input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // One read request; answer is sampled at the falling edge half a cycle after the taking edge
  task automatic rd(input logic [4:0]  dv,
                    input logic [15:0] ad,
                    input logic        ev,
                    input logic [15:0] exp);
    mgmt_devad_in = dv;
    mgmt_addr_in  = ad;
    mgmt_rd_in    = 1'b1;
    cyc(1);
    mgmt_rd_in    = 1'b0;
    check("read valid", {15'h0000, mgmt_rvalid_out}, {15'h0000, ev});
    check("read data", mgmt_rdata_out, exp);
    // An idle edge keeps the strobe low between back-to-back calls
    cyc(1);
    check("read valid gone", {15'h0000, mgmt_rvalid_out}, 16'h0000);
  endtask

  // Wake counter saturation needs 65535 fault cycles, so allow ample time
  initial
  begin
    #400000;
    fails++;
    complete_run();
  end

  initial
  begin
    cyc(5);
    sys_rst_in = 1'b0;
    check("rdata after reset", mgmt_rdata_out, 16'h0000);
    check("rvalid after reset", {15'h0000, mgmt_rvalid_out}, 16'h0000);
    // Fixed fields, no faults; reserved bits read zero
    rd(5'h03, 16'h0008, 1'b1, 16'hB008);
    rd(5'h03, 16'h0008, 1'b1, 16'hB008);
    rd(5'h03, 16'h000E, 1'b1, 16'hA5C3);
    rd(5'h03, 16'h000F, 1'b1, 16'h5A3C);
    // Other device address is ignored, data holds
    rd(5'h01, 16'h0008, 1'b0, 16'h5A3C);
    rd(5'h03, 16'h0014, 1'b1, 16'h0008);
    rd(5'h03, 16'h0009, 1'b1, 16'h0000);
    // Transmit fault is a live level
    transmit_path_fault_in = 1'b1;
    rd(5'h03, 16'h0008, 1'b1, 16'hB808);
    transmit_path_fault_in = 1'b0;
    rd(5'h03, 16'h0008, 1'b1, 16'hB008);
    // Short receive fault pulse is held until read
    receive_path_fault_in = 1'b1;
    cyc(1);
    receive_path_fault_in = 1'b0;
    cyc(3);
    rd(5'h03, 16'h0008, 1'b1, 16'hB408);
    rd(5'h03, 16'h0008, 1'b1, 16'hB008);
    // Persistent fault survives the read clear
    receive_path_fault_in = 1'b1;
    cyc(1);
    rd(5'h03, 16'h0008, 1'b1, 16'hB408);
    rd(5'h03, 16'h0008, 1'b1, 16'hB408);
    receive_path_fault_in = 1'b0;
    rd(5'h03, 16'h0008, 1'b1, 16'hB408);
    rd(5'h03, 16'h0008, 1'b1, 16'hB008);
    // Faults go on through the clearing read and the idle edge after it
    wake_time_fault_in = 1'b1;
    cyc(4);
    rd(5'h03, 16'h0016, 1'b1, 16'h0004);
    wake_time_fault_in = 1'b0;
    rd(5'h03, 16'h0016, 1'b1, 16'h0002);
    rd(5'h03, 16'h0016, 1'b1, 16'h0000);
    // Sublayer reset clears both counter and receive latch
    wake_time_fault_in    = 1'b1;
    receive_path_fault_in = 1'b1;
    cyc(3);
    wake_time_fault_in    = 1'b0;
    receive_path_fault_in = 1'b0;
    pcs_reset_in          = 1'b1;
    cyc(1);
    pcs_reset_in          = 1'b0;
    rd(5'h03, 16'h0016, 1'b1, 16'h0000);
    rd(5'h03, 16'h0008, 1'b1, 16'hB008);
    // Overflow holds at all ones
    wake_time_fault_in = 1'b1;
    cyc(65540);
    wake_time_fault_in = 1'b0;
    rd(5'h03, 16'h0016, 1'b1, 16'hFFFF);
    rd(5'h03, 16'h0016, 1'b1, 16'h0000);
    cyc(2);
    complete_run();
  end
endmodule
